// ==== hdl/adccr_pkg.sv ====
// Purpose: constants for the converter setup and clamp flag registers
// Assumes: 15-bit register address, 8-bit register data
// Notes:   offsets, field positions and reset values
package adccr_pkg;
  localparam int          ADDR_W            = 15;
  localparam int          DATA_W            = 8;
  localparam logic [14:0] CLAMP_UPPER_ADDR  = 15'h001b;
  localparam logic [14:0] DEV_CONFIG_ADDR   = 15'h0020;
  localparam logic [7:0]  CLAMP_UPPER_RESET = 8'h00;
  localparam logic [7:0]  DEV_CONFIG_RESET  = 8'h10;
  localparam logic [7:0]  DEV_CONFIG_MASK   = 8'hff;
  localparam int          ALERT_CLEAR_BIT   = 7;
  localparam int          IDLE_BEHAV_BIT    = 6;
  localparam int          STATUS_APPEND_BIT = 5;
  localparam int          REGULATOR_EN_BIT  = 4;
  localparam int          RSVD_HI_BIT       = 3;
  localparam int          IFACE_MODE_BIT    = 2;
  localparam int          CMD_CYCLE_BIT     = 1;
  localparam int          RSVD_LO_BIT       = 0;
  localparam int          CLAMP_CHANNELS    = 8;
  localparam logic [7:0]  READ_ZERO         = 8'h00;
endpackage

// ==== hdl/adccr_clamp_sync.sv ====
// Purpose: three-stage synchroniser for the clamp flags
// Assumes: flags are asynchronous levels from the analog clamps
// Notes:   a change is taken once stages two and three agree
`timescale 1ns/1ps
module adccr_clamp_sync #(
  parameter int WIDTH = 8
) (
  // clock and control
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             clkEn,
  // flags
  input  wire logic [WIDTH-1:0] flagAsync,
  output logic      [WIDTH-1:0] flagClean
);
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
  logic [WIDTH-1:0] s1_next, s2_next, s3_next, out_next;

  always_comb begin
    s1_next  = flagAsync;
    s2_next  = s1_reg;
    s3_next  = s2_reg;
    out_next = out_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        out_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      out_reg <= '0;
    end else if (clkEn) begin
      s1_reg  <= s1_next;
      s2_reg  <= s2_next;
      s3_reg  <= s3_next;
      out_reg <= out_next;
    end
  end

  assign flagClean = out_reg;
endmodule

// ==== hdl/adccr_regs.sv ====
// Purpose: setup register and upper clamp flag register of the converter
// Assumes: register access port from the serial front end, same clock
// Notes:   read data is registered, one cycle after the read strobe
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Function
// - each upper clamp flag bit reads 1 while the matching input 8 to 15 clamp is active.
// - clamp flags do not latch and drop to 0 once the clamp deactivates.
// - setup bit 7 picks alert clearing, 0 hysteresis on and 1 off, reset 0.
// - setup bit 6 picks output behaviour at frame edges, 0 hold and 1 busy indication.
// - setup bit 5 set makes conversion results carry appended status bits.
// - setup bit 4 enables the internal regulator, resets to 1, clearing it cuts core supply.
// - setup bit 2 selects the interface mode, 1 conversion and 0 register configuration.
// - the register configuration mode command clears the interface mode bit.
// - setup bit 1 picks command mode, 0 two-cycle and 1 single-cycle.
// - setup sits at 0x0020 with reset 0x10, upper clamp flags at 0x001b with reset 0x00.
module adccr_regs (
  // clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  // register access
  input  wire logic [14:0] regAddr,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regWdata,
  output logic      [7:0]  regRdata,
  output logic             regRvalid,
  // interface events
  input  wire logic        regConfigCmd,
  // analog clamp flags, inputs 8 to 15
  input  wire logic [7:0]  clampActiveAsync,
  // setup controls
  output logic             alertHystDisable,
  output logic             outputBusyIndicate,
  output logic             statusAppendEn,
  output logic             internalRegulatorEn,
  output logic             conversionMode,
  output logic             singleCycleCmd,
  output logic             coreSupplyOn
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] clampClean;
  logic [7:0] config_reg, config_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       rvalid_reg, rvalid_next;
  logic [7:0] clamp_reg, clamp_next;

  function automatic logic hit(input logic [14:0] a, input logic [14:0] b);
    hit = (a == b);
  endfunction

  adccr_clamp_sync #(.WIDTH(adccr_pkg::CLAMP_CHANNELS)) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clkEn    (clkEn),
    .flagAsync(clampActiveAsync),
    .flagClean(clampClean)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    config_next = config_reg;
    clamp_next  = clampClean;
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    if (regWrite && hit(regAddr, adccr_pkg::DEV_CONFIG_ADDR)) begin
      config_next = regWdata & adccr_pkg::DEV_CONFIG_MASK;
    end
    if (regConfigCmd) begin
      config_next[adccr_pkg::IFACE_MODE_BIT] = 1'b0;
    end
    if (regRead) begin
      rvalid_next = 1'b1;
      if (hit(regAddr, adccr_pkg::DEV_CONFIG_ADDR)) begin
        rdata_next = config_reg;
      end else if (hit(regAddr, adccr_pkg::CLAMP_UPPER_ADDR)) begin
        rdata_next = clamp_reg;
      end else begin
        rdata_next = adccr_pkg::READ_ZERO;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      config_reg <= adccr_pkg::DEV_CONFIG_RESET;
      clamp_reg  <= adccr_pkg::CLAMP_UPPER_RESET;
      rdata_reg  <= adccr_pkg::READ_ZERO;
      rvalid_reg <= 1'b0;
    end else if (clkEn) begin
      config_reg <= config_next;
      clamp_reg  <= clamp_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered read data and valid, then controls straight from the setup register
  assign regRdata            = rdata_reg;
  assign regRvalid           = rvalid_reg;
  assign alertHystDisable    = config_reg[adccr_pkg::ALERT_CLEAR_BIT];
  assign outputBusyIndicate  = config_reg[adccr_pkg::IDLE_BEHAV_BIT];
  assign statusAppendEn      = config_reg[adccr_pkg::STATUS_APPEND_BIT];
  assign internalRegulatorEn = config_reg[adccr_pkg::REGULATOR_EN_BIT];
  assign coreSupplyOn        = config_reg[adccr_pkg::REGULATOR_EN_BIT];
  assign conversionMode      = config_reg[adccr_pkg::IFACE_MODE_BIT];
  assign singleCycleCmd      = config_reg[adccr_pkg::CMD_CYCLE_BIT];
endmodule

// ==== dv/adccr_checker.sv ====
// Purpose: port checks for the setup and clamp registers
// Assumes: one clock, sync reset
// Notes: bound by name below
`timescale 1ns/1ps
module adccr_checker (
  // clock and control
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        clkEn,
  // register access
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic        regRvalid,
  input wire logic [14:0] regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic [7:0]  regRdata,
  // events and controls
  input wire logic        regConfigCmd,
  input wire logic        alertHystDisable,
  input wire logic        conversionMode,
  input wire logic        internalRegulatorEn,
  input wire logic        coreSupplyOn,
  input wire logic [7:0]  clampActiveAsync
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire wrCfg = clkEn && regWrite && regAddr == 15'h0020;
  wire rdEn = clkEn && regRead;
  sequence s_calm; (clkEn && $stable(clampActiveAsync))[*8]; endsequence
  a_mode_write: assert property (wrCfg && !regConfigCmd |=>
    conversionMode == $past(regWdata[2])) else $error("mode write");
  a_mode_clear: assert property (clkEn && regConfigCmd |=> !conversionMode)
    else $error("mode clear");
  a_reg_write: assert property (wrCfg |=> internalRegulatorEn == $past(regWdata[4]))
    else $error("regulator write");
  a_supply_tie: assert property (coreSupplyOn == internalRegulatorEn)
    else $error("supply tie");
  a_rvalid_set: assert property (rdEn |=> regRvalid)
    else $error("no rvalid");
  a_hold_idle: assert property (!(clkEn && (regWrite || regConfigCmd)) |=>
    $stable(conversionMode) && $stable(alertHystDisable)) else $error("setup moved");
  a_cfg_read: assert property (rdEn && regAddr == 15'h0020 |=> regRdata[7] ==
    $past(alertHystDisable) && regRdata[2] == $past(conversionMode)) else $error("setup read");
  a_clamp_read: assert property (s_calm ##0 (rdEn && regAddr == 15'h001b) |=>
    regRdata == $past(clampActiveAsync)) else $error("clamp read");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind adccr_regs adccr_checker chk (.*);

// ==== dv/adccr_host_model.sv ====
// Purpose: host side model issuing register accesses
// Assumes: one strobe cycle per access
// Notes: idle address and data are scrambled
`timescale 1ns/1ps
module adccr_host_model (
  input wire logic core_clk,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid,
  output logic regWrite = 1'b0,
  output logic regRead = 1'b0,
  output logic [14:0] regAddr = 15'h0000,
  output logic [7:0] regWdata = 8'h00
);
  task wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {regWrite, regAddr, regWdata} <= {1'b1, a, d};
    @(posedge core_clk);
    {regWrite, regAddr, regWdata} <= {1'b0, ~a, ~d};
  endtask
  task rd(input logic [14:0] a, output logic [7:0] d);
    @(posedge core_clk);
    {regRead, regAddr} <= {1'b1, a};
    @(posedge core_clk);
    {regRead, regAddr} <= {1'b0, ~a};
    @(posedge core_clk);
    d = regRvalid ? regRdata : 8'hxx;
  endtask
endmodule

// ==== dv/adc_setup_clamp_status_regs_bench.sv ====
// Purpose: bench for the setup and clamp registers
// Assumes: host model drives the access port
// Notes: setup bits 3 and 0 have no output
`timescale 1ns/1ps
module adc_setup_clamp_status_regs_bench;
  logic core_clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, regConfigCmd = 1'b0;
  logic [7:0] clampActiveAsync = 8'h00, d, e;
  wire [14:0] regAddr;
  wire regWrite, regRead, regRvalid;
  wire [7:0] regWdata, regRdata, ctl;
  wire supplyOn;
  assign ctl[3] = 1'b0;
  assign ctl[0] = 1'b0;
  int error_cnt = 0, compares = 0;
  adccr_regs uut (.*, .alertHystDisable(ctl[7]), .outputBusyIndicate(ctl[6]),
    .statusAppendEn(ctl[5]), .internalRegulatorEn(ctl[4]), .conversionMode(ctl[2]),
    .singleCycleCmd(ctl[1]), .coreSupplyOn(supplyOn));
  adccr_host_model host (.*);
  initial forever #12.5 core_clk = ~core_clk;
  task chk(input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge core_clk);
    error_cnt++;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    host.rd(15'h0020, d);
    chk(d, 8'h10);
    host.rd(15'h001b, d);
    chk(d, 8'h00);
    for (int i = 0; i < 8; i++) begin
      e = 8'h10 | (8'h01 << i);
      host.wr(15'h0020, e);
      host.rd(15'h0020, d);
      chk(d, e);
      chk(ctl & 8'hf6, e & 8'hf6);
      chk({7'h00, supplyOn}, 8'h01);
    end
    host.wr(15'h0020, 8'h00);
    host.rd(15'h0020, d);
    chk(d, 8'h00);
    chk({6'h00, ctl[4], supplyOn}, 8'h00);
    @(posedge core_clk) clkEn <= 1'b0;
    host.wr(15'h0020, 8'h04);
    @(posedge core_clk) clkEn <= 1'b1;
    host.rd(15'h0020, d);
    chk(d, 8'h00);
    host.wr(15'h0020, 8'h14);
    @(posedge core_clk) regConfigCmd <= 1'b1;
    chk(ctl & 8'h04, 8'h04);
    @(posedge core_clk) regConfigCmd <= 1'b0;
    host.rd(15'h0020, d);
    chk(d, 8'h10);
    host.wr(15'h0020, 8'h86);
    @(posedge core_clk) sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    host.rd(15'h0020, d);
    chk(d, 8'h10);
    chk(ctl & 8'hf6, 8'h10);
    chk({7'h00, supplyOn}, 8'h01);
    host.wr(15'h001b, 8'hff);
    host.rd(15'h001b, d);
    chk(d, 8'h00);
    host.rd(15'h0021, d);
    chk(d, 8'h00);
    clampActiveAsync <= 8'ha5;
    repeat (10) @(posedge core_clk);
    host.rd(15'h001b, d);
    chk(d, 8'ha5);
    clampActiveAsync <= 8'h00;
    repeat (10) @(posedge core_clk);
    host.rd(15'h001b, d);
    chk(d, 8'h00);
    wrap_up;
  end
endmodule
